// file: tucs_defines.vh
// Register map, field positions and reset values of the timer clock front end
`ifndef TUCS_DEFINES_VH
`define TUCS_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define TUCS_ADDR_W        2
`define TUCS_ADDR_GATE     2'h0
`define TUCS_ADDR_PRESCALE 2'h1
`define TUCS_ADDR_MODE     2'h2

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define TUCS_GATE_EN       0
`define TUCS_GATE_W        8
`define TUCS_PS0_HI        3
`define TUCS_PS0_LO        0
`define TUCS_PS1_HI        7
`define TUCS_PS1_LO        4
`define TUCS_PS2_HI        9
`define TUCS_PS2_LO        8
`define TUCS_PS3_HI        13
`define TUCS_PS3_LO        12
`define TUCS_PS_MASK       16'h33ff
`define TUCS_MODE_MASK     16'hd7cf
`define TUCS_OPSEL_HI      15
`define TUCS_OPSEL_LO      14
`define TUCS_CCS           12
`define TUCS_TRIG_HI       10
`define TUCS_TRIG_LO       8
`define TUCS_EDGE_HI       7
`define TUCS_EDGE_LO       6
`define TUCS_MD_HI         3
`define TUCS_MD_LO         0

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define TUCS_OPSEL_CK0     2'h0
`define TUCS_OPSEL_CK2     2'h1
`define TUCS_OPSEL_CK1     2'h2
`define TUCS_OPSEL_CK3     2'h3
`define TUCS_TRIG_SW       3'h0
`define TUCS_TRIG_EDGE     3'h1
`define TUCS_TRIG_BOTH     3'h2
`define TUCS_TRIG_MASTER   3'h4
`define TUCS_EDGE_FALL     2'h0
`define TUCS_EDGE_RISE     2'h1
`define TUCS_MODE_ONECNT   3'h4
`define TUCS_GATE_RST      8'h00
`define TUCS_PS_RST        16'h0000
`define TUCS_MODE_RST      16'h0008
`define TUCS_DIV_W         15
`define TUCS_DIV_ZERO      15'h0000
`define TUCS_DIV_ONE       15'h0001

`endif

// file: tucs_prescaler.v
// Shared free-running divider producing one-cycle enables for 2^n rates
`timescale 1ns/1ps
`include "tucs_defines.vh"

module tucs_prescaler (
  input  wire        mclk,
  input  wire        rst,
  input  wire        run,
  input  wire [15:0] prescale,
  output reg  [3:0]  tick
);

  reg  [`TUCS_DIV_W-1:0] divCount;
  wire [3:0]             hit;
  wire [3:0]             expo [0:3];

  assign expo[0] = prescale[`TUCS_PS0_HI:`TUCS_PS0_LO];
  assign expo[1] = prescale[`TUCS_PS1_HI:`TUCS_PS1_LO];
  assign expo[2] = {2'h0, prescale[`TUCS_PS2_HI:`TUCS_PS2_LO]};
  assign expo[3] = {2'h0, prescale[`TUCS_PS3_HI:`TUCS_PS3_LO]};

  // One counter serves all four rates so every channel stays aligned
  always @(posedge mclk) begin
    if (rst || !run) begin
      divCount <= `TUCS_DIV_ZERO;
    end else begin
      divCount <= divCount + `TUCS_DIV_ONE; // [RULE9]
    end
  end

  // Tick when the low n bits of the count are all ones; n = 0 every cycle
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : gTick
      wire [`TUCS_DIV_W-1:0] lowMask;
      assign lowMask = ~({`TUCS_DIV_W{1'b1}} << expo[k]);
      assign hit[k]  = ((divCount & lowMask) == lowMask); // [RULE2] [RULE9]
    end
  endgenerate

  always @(posedge mclk) begin
    if (rst || !run) begin
      tick <= 4'h0;
    end else begin
      tick <= hit;
    end
  end

endmodule

// file: tucs_timer_clock.v
// Timer clock front end: gate, prescaler select, channel 0 count clock
//
// Functional notes
// RULE1: Unit clock runs only while enable bit set
// RULE2: Clock zero is system clock over 2^n
// RULE3: Prescaler fields at fixed bits, gaps zero
// RULE4: Mode bits 15-14 pick operation clock
// RULE5: Bit 12 picks operation clock or pin edge
// RULE6: Software writes zero to reserved mode bits
// RULE7: Only four trigger select codes are valid
// RULE8: One-count retrigger obeys mode low bit
// RULE9: Prescaled clocks are enables from one counter
`timescale 1ns/1ps
`include "tucs_defines.vh"

module tucs_timer_clock (
  input  wire                    mclk,
  input  wire                    rst,
  input  wire [`TUCS_ADDR_W-1:0] regAddr,
  input  wire [15:0]             regWrData,
  input  wire                    regWr,
  input  wire                    regRd,
  output reg  [15:0]             regRdData,
  input  wire                    channelZeroTimerInput,
  input  wire                    softwareStart,
  input  wire                    masterInterrupt,
  input  wire                    channelBusy,
  output reg                     unitClockEnable,
  output reg  [3:0]              prescaledClock,
  output reg                     channelCountTick,
  output reg                     channelStart,
  output reg                     channelStartInterrupt,
  output reg                     triggerSelectError
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [`TUCS_GATE_W-1:0] peripheralClockGate;
  reg  [15:0]             timerPrescalerSelect;
  reg  [15:0]             channel0ModeConfig;
  wire [3:0]              tick;
  wire                    timerUnitClockEnable;

  assign timerUnitClockEnable = peripheralClockGate[`TUCS_GATE_EN];

  always @(posedge mclk) begin
    if (rst) begin
      peripheralClockGate  <= `TUCS_GATE_RST;
      timerPrescalerSelect <= `TUCS_PS_RST;
      channel0ModeConfig   <= `TUCS_MODE_RST;
    end else if (regWr) begin
      case (regAddr)
        `TUCS_ADDR_GATE: begin
          peripheralClockGate <= regWrData[`TUCS_GATE_W-1:0];
        end
        `TUCS_ADDR_PRESCALE: begin
          timerPrescalerSelect <= regWrData & `TUCS_PS_MASK; // [RULE3]
        end
        `TUCS_ADDR_MODE: begin
          // Reserved bits are forced low in case software breaks the rule
          channel0ModeConfig <= regWrData & `TUCS_MODE_MASK; // [RULE6]
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rst || !regRd) begin
      regRdData <= 16'h0000;
    end else begin
      case (regAddr)
        `TUCS_ADDR_GATE: begin
          regRdData <= {8'h00, peripheralClockGate};
        end
        `TUCS_ADDR_PRESCALE: begin
          regRdData <= timerPrescalerSelect;
        end
        `TUCS_ADDR_MODE: begin
          regRdData <= channel0ModeConfig;
        end
        // Unmapped index reads as zero
        default: begin
          regRdData <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Prescaler, cleared and held at zero while the unit clock is gated off
  // ----------------------------------------------------------------
  tucs_prescaler uPrescaler (
    .mclk     (mclk),
    .rst      (rst),
    .run      (timerUnitClockEnable), // [RULE1]
    .prescale (timerPrescalerSelect),
    .tick     (tick)
  );

  always @(posedge mclk) begin
    if (rst) begin
      unitClockEnable <= 1'b0;
      prescaledClock  <= 4'h0;
    end else begin
      unitClockEnable <= timerUnitClockEnable; // [RULE1]
      prescaledClock  <= tick;
    end
  end

  // ----------------------------------------------------------------
  // Timer input pin: sync and edge detect
  // ----------------------------------------------------------------
  reg  [1:0] pinSync;
  reg        pinLast;
  wire       pinRise;
  wire       pinFall;
  reg        validEdge;
  wire [1:0] edgeSel;

  // Two flops settle the pin before any edge logic reads it
  assign edgeSel = channel0ModeConfig[`TUCS_EDGE_HI:`TUCS_EDGE_LO];
  assign pinRise = pinSync[1] & ~pinLast;
  assign pinFall = ~pinSync[1] & pinLast;

  always @(posedge mclk) begin
    if (rst) begin
      pinSync <= 2'h0;
      pinLast <= 1'b0;
    end else begin
      pinSync <= {pinSync[0], channelZeroTimerInput};
      pinLast <= pinSync[1];
    end
  end

  always @* begin
    case (edgeSel)
      `TUCS_EDGE_FALL: validEdge = pinFall;
      `TUCS_EDGE_RISE: validEdge = pinRise;
      default:         validEdge = pinRise | pinFall;
    endcase
  end

  // ----------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------
  reg opTick;

  // Same two-cycle latency as prescaledClock, so both stay lined up
  always @* begin
    case (channel0ModeConfig[`TUCS_OPSEL_HI:`TUCS_OPSEL_LO]) // [RULE4]
      `TUCS_OPSEL_CK0: opTick = tick[0];
      `TUCS_OPSEL_CK2: opTick = tick[2];
      `TUCS_OPSEL_CK1: opTick = tick[1];
      default:         opTick = tick[3];
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      channelCountTick <= 1'b0;
    end else if (channel0ModeConfig[`TUCS_CCS]) begin
      // Pin edges also stop counting while the unit clock is off
      channelCountTick <= validEdge & timerUnitClockEnable; // [RULE5]
    end else begin
      channelCountTick <= opTick; // [RULE5]
    end
  end

  // ----------------------------------------------------------------
  // Start trigger qualification
  // ----------------------------------------------------------------
  wire [2:0] trigSel;
  wire [2:0] modeSel;
  wire       modeLowBit;
  reg        trigRaw;
  reg        trigBad;
  wire       oneCount;
  wire       trigTake;

  assign trigSel    = channel0ModeConfig[`TUCS_TRIG_HI:`TUCS_TRIG_LO];
  assign modeSel    = channel0ModeConfig[`TUCS_MD_HI:`TUCS_MD_LO+1];
  assign modeLowBit = channel0ModeConfig[`TUCS_MD_LO];
  assign oneCount   = (modeSel == `TUCS_MODE_ONECNT);

  always @* begin
    trigBad = 1'b0;
    // Software start stays valid under every legal code
    case (trigSel) // [RULE7]
      `TUCS_TRIG_SW: begin
        trigRaw = softwareStart;
      end
      `TUCS_TRIG_EDGE: begin
        trigRaw = softwareStart | validEdge;
      end
      `TUCS_TRIG_BOTH: begin
        trigRaw = softwareStart | pinRise | pinFall;
      end
      `TUCS_TRIG_MASTER: begin
        trigRaw = softwareStart | masterInterrupt;
      end
      default: begin
        trigRaw = 1'b0;
        trigBad = 1'b1;
      end
    endcase
  end

  // Retriggers during a one-count run are dropped when the low bit is 0
  assign trigTake = trigRaw & timerUnitClockEnable &
                    ~(oneCount & channelBusy & ~modeLowBit); // [RULE8]

  always @(posedge mclk) begin
    if (rst) begin
      channelStart          <= 1'b0;
      channelStartInterrupt <= 1'b0;
      triggerSelectError    <= 1'b0;
    end else begin
      channelStart          <= trigTake;
      channelStartInterrupt <= trigTake & oneCount & channelBusy; // [RULE8]
      triggerSelectError    <= trigBad; // [RULE7]
    end
  end

endmodule

// file: tucs_timer_clock_properties.sv
// Port checker for the timer clock front end
`timescale 1ns/1ps
module tucs_timer_clock_chk (
  input wire        mclk,
  input wire        rst,
  input wire [1:0]  regAddr,
  input wire [15:0] regWrData,
  input wire        regWr,
  input wire        softwareStart,
  input wire        channelBusy,
  input wire        unitClockEnable,
  input wire [3:0]  prescaledClock,
  input wire        channelCountTick,
  input wire        channelStart,
  input wire        channelStartInterrupt,
  input wire        triggerSelectError
);
  // Register shadows; q counts quiet cycles so pipelines can settle
  reg  [3:0]  ps;
  reg  [15:0] md;
  reg  [3:0]  q;
  wire [1:0]  sel = {md[14], md[15]};
  wire        st  = q > 4'h6 && unitClockEnable;
  wire        oc  = md[3:1] == 3'h4 && q > 4'h3;
  wire        bad = (md[10] && md[9:8] != 2'h0) || md[9:8] == 2'h3;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  always @(posedge mclk) begin
    q <= (rst || regWr) ? 4'h0 : q + {3'h0, q != 4'hf};
    if (rst) begin
      ps <= 4'h0;
      md <= 16'h0008;
    end else if (regWr && regAddr == 2'h1)
      ps <= regWrData[3:0];
    else if (regWr && regAddr == 2'h2)
      md <= regWrData & 16'hd7cf;
  end
  a_gate_stop: assert property (
    !unitClockEnable [*5] |-> prescaledClock == 4'h0 && !channelCountTick)
    else $error("ticks while gated");
  a_ck0_every: assert property (
    st && ps == 4'h0 |-> prescaledClock[0]) else $error("ck0 missing");
  a_ck0_half: assert property (
    st && ps == 4'h1 && prescaledClock[0] |=>
    !prescaledClock[0] ##1 prescaledClock[0]) else $error("ck0 period");
  a_tick_src: assert property (
    st && !md[12] && channelCountTick |->
    prescaledClock[sel] || $past(prescaledClock[sel]))
    else $error("tick source");
  a_trig_err: assert property (
    q > 4'h3 |-> triggerSelectError == bad) else $error("error flag");
  a_trig_block: assert property (
    q > 4'h3 && bad && softwareStart |=> !channelStart)
    else $error("start on bad code");
  a_retrig_off: assert property (
    oc && !md[0] && channelBusy && softwareStart |=>
    !channelStart && !channelStartInterrupt) else $error("retrigger taken");
  a_retrig_on: assert property (
    oc && md[0] && !bad && unitClockEnable && channelBusy && softwareStart
    |=> channelStart && channelStartInterrupt) else $error("retrigger lost");
endmodule
bind tucs_timer_clock tucs_timer_clock_chk u_chk (.mclk(mclk), .rst(rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .softwareStart(softwareStart), .channelBusy(channelBusy),
  .unitClockEnable(unitClockEnable), .prescaledClock(prescaledClock),
  .channelCountTick(channelCountTick), .channelStart(channelStart),
  .channelStartInterrupt(channelStartInterrupt),
  .triggerSelectError(triggerSelectError));

// file: tucs_timer_clock_bench.sv
// Self-checking bench of the timer clock front end
`timescale 1ns/1ps
module tucs_timer_clock_bench;
  reg         mclk, rst, regWr, regRd, pin, sw, mi, busy;
  reg  [1:0]  regAddr;
  reg  [15:0] regWrData;
  wire [15:0] regRdData;
  wire [3:0]  pck;
  wire        uce, tick, cs, csi, err;
  int         nMismatch, nTests, cyc, c, p, s, i, k;
  logic [15:0] ex [4] = '{16'h0020, 16'h0008, 16'h0010, 16'h0040};
  tucs_timer_clock u_tucs_timer_clock (.mclk(mclk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .channelZeroTimerInput(pin),
    .softwareStart(sw), .masterInterrupt(mi), .channelBusy(busy),
    .unitClockEnable(uce), .prescaledClock(pck), .channelCountTick(tick),
    .channelStart(cs), .channelStartInterrupt(csi),
    .triggerSelectError(err));
  task close_out;
    begin
      if (nMismatch == 0 && nTests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] sn, input [15:0] e);
    begin
      nTests++;
      if (sn !== e) begin
        nMismatch++;
        $display("mismatch %s exp %h seen %h", nm, e, sn);
      end
    end
  endtask
  task wr(input [1:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [1:0] a, input [15:0] e);
    begin
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      chk("rdata", regRdData, e);
      @(negedge mclk);
      chk("rdidle", regRdData, 16'h0000);
    end
  endtask
  // Pin makes five full periods while ticks are counted over 64 cycles
  task run;
    begin
      c = 0;
      p = 0;
      s = 0;
      repeat (8) @(posedge mclk);
      for (k = 0; k < 64; k++) begin
        @(posedge mclk);
        pin <= k < 40 && k[2];
        @(negedge mclk);
        c += tick;
        p += pck[0];
        s += cs;
      end
    end
  endtask
  task fire(input [1:0] w);
    begin
      repeat (4) @(posedge mclk);
      {mi, sw} <= w;
      @(posedge mclk);
      {mi, sw} <= 2'h0;
      s = 0;
      i = 0;
      repeat (4) begin
        @(negedge mclk);
        s += cs;
        i += csi;
      end
    end
  endtask
  task t_regs;
    begin
      rd(2'h2, 16'h0008);
      wr(2'h3, 16'hffff);
      rd(2'h3, 16'h0000);
      wr(2'h1, 16'hffff);
      rd(2'h1, 16'h33ff);
      wr(2'h2, 16'hffff);
      rd(2'h2, 16'hd7cf);
      rd(2'h0, 16'h0000);
    end
  endtask
  task t_clk;
    int j;
    begin
      wr(2'h1, 16'h0000);
      wr(2'h2, 16'h0000);
      wr(2'h0, 16'h0001);
      @(negedge mclk);
      chk("uce", {15'h0, uce}, 16'h0000);
      @(negedge mclk);
      chk("uce", {15'h0, uce}, 16'h0001);
      run;
      chk("ck0", p[15:0], 16'h0040);
      wr(2'h0, 16'h0000);
      wr(2'h1, 16'h0321);
      run;
      chk("gated", c[15:0] + p[15:0], 16'h0000);
      chk("uce", {15'h0, uce}, 16'h0000);
      wr(2'h0, 16'h0001);
      for (j = 0; j < 4; j++) begin
        wr(2'h2, {j[1:0], 14'h0000});
        run;
        chk("ck0", p[15:0], 16'h0020);
        chk("tick", c[15:0], ex[j]);
      end
      for (j = 0; j < 3; j++) begin
        wr(2'h2, {8'h10, j[1:0], 6'h00});
        run;
        chk("pin", c[15:0], j == 2 ? 16'h000a : 16'h0005);
      end
    end
  endtask
  task t_trig;
    int j;
    begin
      for (j = 0; j < 8; j++) begin
        wr(2'h2, {5'h00, j[2:0], 8'h00});
        fire(2'h2);
        chk("master", s[15:0], {15'h0, j == 4});
        fire(2'h1);
        chk("start", s[15:0], {15'h0, j != 3 && j < 5});
        chk("error", {15'h0, err}, {15'h0, j == 3 || j > 4});
      end
      wr(2'h2, 16'h0200);
      run;
      chk("edges", s[15:0], 16'h000a);
      wr(2'h2, 16'h0140);
      run;
      chk("edge", s[15:0], 16'h0005);
      @(posedge mclk);
      busy <= 1'b1;
      wr(2'h2, 16'h0008);
      fire(2'h1);
      chk("retrig", s[15:0] + i[15:0], 16'h0000);
      wr(2'h2, 16'h0009);
      fire(2'h1);
      chk("retrig", {s[7:0], i[7:0]}, 16'h0101);
      @(posedge mclk);
      busy <= 1'b0;
      wr(2'h0, 16'h0000);
      fire(2'h1);
      chk("gated", s[15:0], 16'h0000);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Ceiling well above the roughly one thousand cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      close_out;
    end
  end
  initial begin
    {rst, regWr, regRd, pin, sw, mi, busy} = 7'h40;
    regAddr = 2'h0;
    regWrData = 16'h0000;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_clk;
    t_trig;
    close_out;
  end
endmodule
